// *** core/tu2_defs.svh ***
// Register map, field positions and reset values for the timer unit 2 pin function select block.
// Included by the top-level design file of the block and by the bench; holds definitions only.
`ifndef TU2_DEFS_SVH
`define TU2_DEFS_SVH

// ----------------------------------------------------------------------------
// Register port
// ----------------------------------------------------------------------------
`define TU2_ADDR_W 8
`define TU2_PFS_OFFSET 8'h00
`define TU2_PFS_RESET 32'h0000_0000
// Only the implemented fields are stored; reserved and unused bits read as zero
`define TU2_PFS_WMASK 32'h03FF_1FFF
`define TU2_READ_IDLE 32'h0000_0000

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define TU2_CAP21_HI 25
`define TU2_CAP21_LO 23
`define TU2_CAP20_HI 22
`define TU2_CAP20_LO 20
`define TU2_FRUN_HI 19
`define TU2_FRUN_LO 18
`define TU2_TRIP_HI 17
`define TU2_TRIP_LO 16
`define TU2_RSV_HI 15
`define TU2_RSV_LO 13
`define TU2_GPIO_BIT 12
`define TU2_WAVE_LSB 0
`define TU2_WAVE_W 2
`define TU2_WAVE_N 6

// ----------------------------------------------------------------------------
// Pin synchroniser lanes
// ----------------------------------------------------------------------------
`define TU2_PIN_N 8
`define TU2_LANE_C20_P0 0
`define TU2_LANE_C20_P1 1
`define TU2_LANE_C21_P0 2
`define TU2_LANE_C21_P1 3
`define TU2_LANE_FR_P0 4
`define TU2_LANE_FR_P1 5
`define TU2_LANE_TR_P0 6
`define TU2_LANE_TR_P1 7
`define TU2_SETTLE_CYC 2'h3

`endif

// *** core/tu2_pkg.sv ***
// Types shared by the timer unit 2 pin function select modules.
// Assumes nothing of its surroundings.
package tu2_pkg;

    // Input source codes; 2-bit fields are zero-extended onto this type
    typedef enum logic [2:0] {
        TU2_SRC_PIN0 = 3'h0,
        TU2_SRC_PIN0_ALT = 3'h1,
        TU2_SRC_PIN1 = 3'h2,
        TU2_SRC_BAD3 = 3'h3,
        TU2_SRC_SYNC_A = 3'h4,
        TU2_SRC_SYNC_B = 3'h5,
        TU2_SRC_BAD6 = 3'h6,
        TU2_SRC_BAD7 = 3'h7
    } tu2_in_src_t;

    // Waveform output enable codes
    typedef enum logic [1:0] {
        TU2_OUT_NONE = 2'h0,
        TU2_OUT_PIN0 = 2'h1,
        TU2_OUT_PIN1 = 2'h2,
        TU2_OUT_BAD = 2'h3
    } tu2_out_en_t;

endpackage : tu2_pkg

// *** core/tu2_in_sel.sv ***
// One input routing multiplexer: two pins and two internal sync lines.
// Assumes its inputs are already in the clock domain of the user.
`timescale 1ns/1ps
`default_nettype none
module tu2_in_sel (
    input wire tu2_pkg::tu2_in_src_t code,
    input wire logic pin0,
    input wire logic pin1,
    input wire logic sync_a,
    input wire logic sync_b,
    output logic sel
);
    import tu2_pkg::*;

    always_comb begin
        case (code)
            TU2_SRC_PIN0, TU2_SRC_PIN0_ALT: sel = pin0;
            TU2_SRC_PIN1: sel = pin1;
            TU2_SRC_SYNC_A: sel = sync_a;
            TU2_SRC_SYNC_B: sel = sync_b;
            // Forbidden codes deselect every source
            default: sel = 1'b0;
        endcase
    end

endmodule : tu2_in_sel
`default_nettype wire

// *** core/tu2_out_sel.sv ***
// One waveform output router: drives pin option zero, option one or neither.
// Assumes the waveform value and trip switch come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module tu2_out_sel (
    input wire tu2_pkg::tu2_out_en_t code,
    input wire logic wave,
    input wire logic to_gpio,
    output logic p0_out,
    output logic p0_oe,
    output logic p1_out,
    output logic p1_oe
);
    import tu2_pkg::*;

    always_comb begin
        p0_oe = 1'b0;
        p1_oe = 1'b0;
        case (code)
            TU2_OUT_PIN0: p0_oe = !to_gpio;
            TU2_OUT_PIN1: p1_oe = !to_gpio;
            // No output, and forbidden code treated as no output
            default: begin
                p0_oe = 1'b0;
                p1_oe = 1'b0;
            end
        endcase
        // Data is masked so an idle pin never shows a stale waveform
        p0_out = p0_oe & wave;
        p1_out = p1_oe & wave;
    end

endmodule : tu2_out_sel
`default_nettype wire

// *** core/tu2_pin_func_sel.sv ***
// Timer unit 2 pin function select: one selection register and the pin routing it steers.
// Assumes a single-cycle register port on CLK, and timer, serial and trip-flag logic on CLK.
// Function
// - Capture 21 source bits 25:23 reset 000; 000/001 pin zero, 010 pin one.
// - Capture 21 code 100 takes serial channel 1 line sync, 101 channel 5.
// - Capture 20 source bits 22:20 reset 000; 000/001 pin zero, 010 pin one.
// - Capture 20 code 100 takes serial channel 0 line sync, 101 channel 4.
// - Free-run clock bits 19:18 reset 00; 00/01 pin zero, 10 pin one.
// - Trip input bits 17:16 reset 00; 00/01 pin zero, 10 pin one.
// - Bits 15:13 read zero; software writes zero there.
// - Bit 12 set lets the trip flag hand all six waveform pins to GPIO.
// - Wave 25 bits 11:10 reset 00 none; 01 pin zero, 10 pin one.
// - Wave 24 bits 9:8 reset 00 none; 01 pin zero, 10 pin one.
// - Wave 23 bits 7:6 reset 00 none; 01 pin zero, 10 pin one.
// - Wave 22 bits 5:4 reset 00 none; 01 pin zero, 10 pin one.
// - Wave 21 bits 3:2 reset 00 none; 01 pin zero, 10 pin one.
// - Wave 20 bits 1:0 reset 00 none; 01 pin zero, 10 pin one.
// - Reads return the stored value and change nothing.
// - Deep standby exit reset leaves the register unchanged.
`timescale 1ns/1ps
`default_nettype none
`include "tu2_defs.svh"
module tu2_pin_func_sel #(
    parameter int WAVE_N = `TU2_WAVE_N
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic DSTBY_RST_N,
    input wire logic [`TU2_ADDR_W-1:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire logic CAP20_PIN0,
    input wire logic CAP20_PIN1,
    input wire logic CAP21_PIN0,
    input wire logic CAP21_PIN1,
    input wire logic LINE_SYNC_CH0,
    input wire logic LINE_SYNC_CH1,
    input wire logic LINE_SYNC_CH4,
    input wire logic LINE_SYNC_CH5,
    input wire logic FREERUN_PIN0,
    input wire logic FREERUN_PIN1,
    input wire logic TRIP_PIN0,
    input wire logic TRIP_PIN1,
    input wire logic TRIP_EVENT_FLAG,
    input wire logic [WAVE_N-1:0] WAVE_IN,
    output logic CAPTURE20_IN,
    output logic CAPTURE21_IN,
    output logic FREERUN_CLOCK_IN,
    output logic DEAD_TIME_TRIP_IN,
    output logic TRIP_GPIO_ACTIVE,
    output logic [WAVE_N-1:0] WAVE_PIN0_OUT,
    output logic [WAVE_N-1:0] WAVE_PIN0_OE,
    output logic [WAVE_N-1:0] WAVE_PIN1_OUT,
    output logic [WAVE_N-1:0] WAVE_PIN1_OE
);
    import tu2_pkg::*;

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    logic [31:0] sel_reg_ff;
    logic [31:0] nxt_sel_reg;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic [`TU2_PIN_N-1:0] pin_raw;
    logic [`TU2_PIN_N-1:0] pin_meta_ff;
    logic [`TU2_PIN_N-1:0] pin_sync_ff;
    logic hit;
    logic any_rst;
    logic trip_gpio;
    logic cap20_sel;
    logic cap21_sel;
    logic frun_sel;
    logic trip_sel;
    logic [WAVE_N-1:0] p0_out;
    logic [WAVE_N-1:0] p0_oe;
    logic [WAVE_N-1:0] p1_out;
    logic [WAVE_N-1:0] p1_oe;
    logic cap20_ff;
    logic cap21_ff;
    logic frun_ff;
    logic trip_ff;
    logic trip_gpio_ff;
    logic [WAVE_N-1:0] p0_out_ff;
    logic [WAVE_N-1:0] p0_oe_ff;
    logic [WAVE_N-1:0] p1_out_ff;
    logic [WAVE_N-1:0] p1_oe_ff;
    logic [1:0] settle_ff;

    assign hit = (ADDR == `TU2_PFS_OFFSET);
    // Deep standby exit clears the pin path but not the selection register
    assign any_rst = !RST_N || !DSTBY_RST_N;

    // ------------------------------------------------------------------------
    // Selection register
    // ------------------------------------------------------------------------
    always_comb begin
        nxt_sel_reg = sel_reg_ff;
        if (WR && hit) begin
            // Reserved bits are never stored, so they always read as zero
            nxt_sel_reg = WDATA & `TU2_PFS_WMASK;
        end
    end

    // Only the power-on style reset restores the initial values
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            sel_reg_ff <= `TU2_PFS_RESET;
        end else begin
            sel_reg_ff <= nxt_sel_reg;
        end
    end

    // Read data stands only in the cycle after the strobe; reads never touch state
    always_comb begin
        nxt_rdata = `TU2_READ_IDLE;
        if (RD && hit) begin
            nxt_rdata = sel_reg_ff;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            rdata_ff <= `TU2_READ_IDLE;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign RDATA = rdata_ff;

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    always_comb begin
        pin_raw = '0;
        pin_raw[`TU2_LANE_C20_P0] = CAP20_PIN0;
        pin_raw[`TU2_LANE_C20_P1] = CAP20_PIN1;
        pin_raw[`TU2_LANE_C21_P0] = CAP21_PIN0;
        pin_raw[`TU2_LANE_C21_P1] = CAP21_PIN1;
        pin_raw[`TU2_LANE_FR_P0] = FREERUN_PIN0;
        pin_raw[`TU2_LANE_FR_P1] = FREERUN_PIN1;
        pin_raw[`TU2_LANE_TR_P0] = TRIP_PIN0;
        pin_raw[`TU2_LANE_TR_P1] = TRIP_PIN1;
    end

    always_ff @(posedge CLK) begin
        if (any_rst) begin
            pin_meta_ff <= '0;
            pin_sync_ff <= '0;
        end else begin
            pin_meta_ff <= pin_raw;
            pin_sync_ff <= pin_meta_ff;
        end
    end

    // ------------------------------------------------------------------------
    // Input routing
    // ------------------------------------------------------------------------
    // Capture 21: pins, or line sync of serial channels 1 and 5
    tu2_in_sel u_cap21 (
        .code(tu2_in_src_t'(sel_reg_ff[`TU2_CAP21_HI:`TU2_CAP21_LO])),
        .pin0(pin_sync_ff[`TU2_LANE_C21_P0]),
        .pin1(pin_sync_ff[`TU2_LANE_C21_P1]),
        .sync_a(LINE_SYNC_CH1),
        .sync_b(LINE_SYNC_CH5),
        .sel(cap21_sel)
    );

    // Capture 20: pins, or line sync of serial channels 0 and 4
    tu2_in_sel u_cap20 (
        .code(tu2_in_src_t'(sel_reg_ff[`TU2_CAP20_HI:`TU2_CAP20_LO])),
        .pin0(pin_sync_ff[`TU2_LANE_C20_P0]),
        .pin1(pin_sync_ff[`TU2_LANE_C20_P1]),
        .sync_a(LINE_SYNC_CH0),
        .sync_b(LINE_SYNC_CH4),
        .sel(cap20_sel)
    );

    // Two-bit fields widen with a zero, so code 11 lands on a forbidden source
    tu2_in_sel u_frun (
        .code(tu2_in_src_t'({1'b0, sel_reg_ff[`TU2_FRUN_HI:`TU2_FRUN_LO]})),
        .pin0(pin_sync_ff[`TU2_LANE_FR_P0]),
        .pin1(pin_sync_ff[`TU2_LANE_FR_P1]),
        .sync_a(1'b0),
        .sync_b(1'b0),
        .sel(frun_sel)
    );

    // Trip input to the waveform generator
    tu2_in_sel u_trip (
        .code(tu2_in_src_t'({1'b0, sel_reg_ff[`TU2_TRIP_HI:`TU2_TRIP_LO]})),
        .pin0(pin_sync_ff[`TU2_LANE_TR_P0]),
        .pin1(pin_sync_ff[`TU2_LANE_TR_P1]),
        .sync_a(1'b0),
        .sync_b(1'b0),
        .sel(trip_sel)
    );

    // ------------------------------------------------------------------------
    // Waveform output routing
    // ------------------------------------------------------------------------
    // The flag comes from timer logic on this clock, so it needs no synchroniser
    assign trip_gpio = sel_reg_ff[`TU2_GPIO_BIT] & TRIP_EVENT_FLAG;

    genvar gi;
    generate
        for (gi = 0; gi < WAVE_N; gi = gi + 1) begin : g_wave
            // Two-bit enable field per channel, channel 20 in the lowest pair
            tu2_out_sel u_out (
                .code(tu2_out_en_t'(sel_reg_ff[`TU2_WAVE_LSB + gi*`TU2_WAVE_W +: `TU2_WAVE_W])),
                .wave(WAVE_IN[gi]),
                .to_gpio(trip_gpio),
                .p0_out(p0_out[gi]),
                .p0_oe(p0_oe[gi]),
                .p1_out(p1_out[gi]),
                .p1_oe(p1_oe[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Output flops
    // ------------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (any_rst) begin
            cap20_ff <= 1'b0;
            cap21_ff <= 1'b0;
            frun_ff <= 1'b0;
            trip_ff <= 1'b0;
        end else begin
            cap20_ff <= cap20_sel;
            cap21_ff <= cap21_sel;
            frun_ff <= frun_sel;
            trip_ff <= trip_sel;
        end
    end

    always_ff @(posedge CLK) begin
        if (any_rst) begin
            trip_gpio_ff <= 1'b0;
            p0_out_ff <= '0;
            p0_oe_ff <= '0;
            p1_out_ff <= '0;
            p1_oe_ff <= '0;
        end else begin
            trip_gpio_ff <= trip_gpio;
            p0_out_ff <= p0_out;
            p0_oe_ff <= p0_oe;
            p1_out_ff <= p1_out;
            p1_oe_ff <= p1_oe;
        end
    end

    assign CAPTURE20_IN = cap20_ff;
    assign CAPTURE21_IN = cap21_ff;
    assign FREERUN_CLOCK_IN = frun_ff;
    assign DEAD_TIME_TRIP_IN = trip_ff;
    assign TRIP_GPIO_ACTIVE = trip_gpio_ff;
    assign WAVE_PIN0_OUT = p0_out_ff;
    assign WAVE_PIN0_OE = p0_oe_ff;
    assign WAVE_PIN1_OUT = p1_out_ff;
    assign WAVE_PIN1_OE = p1_oe_ff;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    // Counts cycles since any reset so pin paths are checked only once refilled
    always_ff @(posedge CLK) begin
        if (any_rst) begin
            settle_ff <= 2'h0;
        end else if (settle_ff != `TU2_SETTLE_CYC) begin
            settle_ff <= settle_ff + 2'h1;
        end
    end

    sequence s_write;
        WR && hit;
    endsequence

    sequence s_read_back;
        RD && hit && !WR;
    endsequence

    a_write_read_back: assert property (
        @(posedge CLK) disable iff (!RST_N)
        s_write ##1 !WR ##1 s_read_back |=> RDATA == ($past(WDATA, 3) & `TU2_PFS_WMASK)
    ) else $error("read after write did not return the stored value");

    a_read_no_side: assert property (
        @(posedge CLK) disable iff (!RST_N)
        RD && !WR |=> $stable(sel_reg_ff) ##1 RDATA == `TU2_READ_IDLE || $past(RD)
    ) else $error("read changed the register or read data lingered");

    a_reserved_zero: assert property (
        @(posedge CLK) disable iff (!RST_N)
        RDATA[`TU2_RSV_HI:`TU2_RSV_LO] == 3'h0
    ) else $error("reserved bits read nonzero");

    a_reset_initial: assert property (
        @(posedge CLK)
        !RST_N |=> sel_reg_ff == `TU2_PFS_RESET && RDATA == `TU2_READ_IDLE
    ) else $error("register did not reset to its initial value");

    a_standby_keeps: assert property (
        @(posedge CLK) disable iff (!RST_N)
        !DSTBY_RST_N && !WR |=> $stable(sel_reg_ff)
    ) else $error("deep standby reset altered the register");

    a_cap21_pin_one: assert property (
        @(posedge CLK) disable iff (any_rst)
        settle_ff == `TU2_SETTLE_CYC && sel_reg_ff[`TU2_CAP21_HI:`TU2_CAP21_LO] == 3'h2
        |=> CAPTURE21_IN == $past(CAP21_PIN1, 3)
    ) else $error("capture 21 did not follow pin option one");

    a_cap21_sync_b: assert property (
        @(posedge CLK) disable iff (any_rst)
        sel_reg_ff[`TU2_CAP21_HI:`TU2_CAP21_LO] == 3'h5 |=> CAPTURE21_IN == $past(LINE_SYNC_CH5)
    ) else $error("capture 21 did not follow serial channel 5 sync");

    a_cap20_sync_a: assert property (
        @(posedge CLK) disable iff (any_rst)
        sel_reg_ff[`TU2_CAP20_HI:`TU2_CAP20_LO] == 3'h4 |=> CAPTURE20_IN == $past(LINE_SYNC_CH0)
    ) else $error("capture 20 did not follow serial channel 0 sync");

    a_frun_forbidden: assert property (
        @(posedge CLK) disable iff (any_rst)
        sel_reg_ff[`TU2_FRUN_HI:`TU2_FRUN_LO] == 2'h3 |=> !FREERUN_CLOCK_IN
    ) else $error("forbidden free-run code still routed a pin");

    a_trip_pin_zero: assert property (
        @(posedge CLK) disable iff (any_rst)
        settle_ff == `TU2_SETTLE_CYC && sel_reg_ff[`TU2_TRIP_HI:`TU2_TRIP_LO] == 2'h1
        |=> DEAD_TIME_TRIP_IN == $past(TRIP_PIN0, 3)
    ) else $error("trip input did not follow pin option zero");

    a_trip_to_gpio: assert property (
        @(posedge CLK) disable iff (any_rst)
        sel_reg_ff[`TU2_GPIO_BIT] && TRIP_EVENT_FLAG |=> TRIP_GPIO_ACTIVE && WAVE_PIN0_OE == '0
            && WAVE_PIN1_OE == '0
    ) else $error("trip event did not release the waveform pins");

    a_wave20_pin_zero: assert property (
        @(posedge CLK) disable iff (any_rst)
        sel_reg_ff[1:0] == 2'h1 && !trip_gpio |=> WAVE_PIN0_OE[0] && !WAVE_PIN1_OE[0]
            && WAVE_PIN0_OUT[0] == $past(WAVE_IN[0])
    ) else $error("wave 20 did not drive pin option zero");

    a_wave25_pin_one: assert property (
        @(posedge CLK) disable iff (any_rst)
        sel_reg_ff[11:10] == 2'h2 && !trip_gpio |=> WAVE_PIN1_OE[5] && !WAVE_PIN0_OE[5]
    ) else $error("wave 25 did not drive pin option one");

    a_wave_none: assert property (
        @(posedge CLK) disable iff (any_rst)
        sel_reg_ff[9:2] == 8'h00 |=> WAVE_PIN0_OE[4:1] == 4'h0 && WAVE_PIN1_OE[4:1] == 4'h0
    ) else $error("disabled wave channel drove a pin");

endmodule : tu2_pin_func_sel
`default_nettype wire

// *** verif/tu2_far_model.sv ***
// Far-side model: timer, serial-unit and trip-flag logic plus the pads that feed the selector.
// Assumes the bench sets target levels on CLK; they reach the selector one edge later.
`timescale 1ns/1ps
`default_nettype none
module tu2_far_model (
    input wire logic CLK,
    input wire logic [7:0] pin_set,
    input wire logic [3:0] sync_set,
    input wire logic [5:0] wave_set,
    input wire logic flag_set,
    output logic [7:0] pin_ff,
    output logic [3:0] sync_ff,
    output logic [5:0] wave_ff,
    output logic flag_ff
);
    // ------------------------------------------------------------------------
    // Registered sources
    // ------------------------------------------------------------------------
    // Timer and serial outputs come from flops on CLK, so the selector never sees a mid-cycle edge
    always_ff @(posedge CLK) begin
        pin_ff <= pin_set;
        sync_ff <= sync_set;
        wave_ff <= wave_set;
        flag_ff <= flag_set;
    end
endmodule : tu2_far_model
`default_nettype wire

// *** verif/tu2_pin_func_sel_test.sv ***
// Self-checking bench for the timer unit 2 pin function select block.
// Assumes the far-side model file and the design files are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "tu2_defs.svh"
module tu2_pin_func_sel_test;
    import tu2_pkg::*;
    logic clk, rst_n, dstby_rst_n, wr, rd, flag_set, flag;
    logic [`TU2_ADDR_W-1:0] addr;
    logic [31:0] wdata, rdata, got, word;
    logic [7:0] pin_set, pins;
    logic [3:0] sync_set, syncs;
    logic [5:0] wave_set, waves, p0_out, p0_oe, p1_out, p1_oe;
    logic cap20, cap21, frun, trip, gpio;
    int mismatches, tests_run, cycles;

    tu2_far_model tu2_far_model_i (.CLK(clk), .pin_set(pin_set), .sync_set(sync_set), .wave_set(wave_set),
        .flag_set(flag_set), .pin_ff(pins), .sync_ff(syncs), .wave_ff(waves), .flag_ff(flag));

    tu2_pin_func_sel tu2_pin_func_sel_i (.CLK(clk), .RST_N(rst_n), .DSTBY_RST_N(dstby_rst_n),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .CAP20_PIN0(pins[0]), .CAP20_PIN1(pins[1]), .CAP21_PIN0(pins[2]), .CAP21_PIN1(pins[3]),
        .LINE_SYNC_CH0(syncs[0]), .LINE_SYNC_CH1(syncs[1]), .LINE_SYNC_CH4(syncs[2]),
        .LINE_SYNC_CH5(syncs[3]), .FREERUN_PIN0(pins[4]), .FREERUN_PIN1(pins[5]),
        .TRIP_PIN0(pins[6]), .TRIP_PIN1(pins[7]), .TRIP_EVENT_FLAG(flag), .WAVE_IN(waves),
        .CAPTURE20_IN(cap20), .CAPTURE21_IN(cap21), .FREERUN_CLOCK_IN(frun),
        .DEAD_TIME_TRIP_IN(trip), .TRIP_GPIO_ACTIVE(gpio), .WAVE_PIN0_OUT(p0_out),
        .WAVE_PIN0_OE(p0_oe), .WAVE_PIN1_OUT(p1_out), .WAVE_PIN1_OE(p1_oe));

    // ------------------------------------------------------------------------
    // Clock, timeout and verdict
    // ------------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic stop_test;
        if (mismatches == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test

    // The full run needs about 530 cycles, well inside the 3000-cycle budget that stops a hang
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            stop_test();
        end
    end

    // ------------------------------------------------------------------------
    // Register port and compare helpers
    // ------------------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic reg_write(input logic [`TU2_ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : reg_write

    // Data stands only in the cycle after the strobe, so it is taken mid-cycle there
    task automatic reg_read(input logic [`TU2_ADDR_W-1:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask : reg_read

    function automatic logic sel_in(input logic [2:0] c, input logic p0, input logic p1,
                                    input logic sa, input logic sb);
        case (c)
            3'h0, 3'h1: sel_in = p0;
            3'h2: sel_in = p1;
            3'h4: sel_in = sa;
            3'h5: sel_in = sb;
            default: sel_in = 1'b0;
        endcase
    endfunction : sel_in

    // ------------------------------------------------------------------------
    // Routing sweep: every legal code against 16 source patterns
    // ------------------------------------------------------------------------
    task automatic run_routes;
        logic [2:0] c;
        logic [1:0] f;
        logic ga;
        logic [5:0] e0, e1;
        for (int k = 0; k < 6; k++) begin
            if (k != 3) begin
                c = 3'(k);
                f = 2'(k % 3);
                word = {6'h00, c, c, f, f, 3'b000, c[0], 12'h000};
                for (int i = 0; i < 6; i++) begin
                    word[2*i +: 2] = 2'((k + i) % 3);
                end
                reg_write(`TU2_PFS_OFFSET, word);
                reg_read(`TU2_PFS_OFFSET, got);
                check("select word", word, got);
                @(negedge clk);
                check("read data after", 32'h0000_0000, rdata);
                for (int p = 0; p < 16; p++) begin
                    @(posedge clk);
                    pin_set <= {4'(p), ~4'(p)};
                    sync_set <= 4'(p) ^ 4'h6;
                    wave_set <= {2'(p), 4'(p)};
                    flag_set <= p[3];
                    repeat (5) @(posedge clk);
                    @(negedge clk);
                    ga = c[0] & flag_set;
                    for (int i = 0; i < 6; i++) begin
                        e0[i] = (((k + i) % 3) == 1) && !ga;
                        e1[i] = (((k + i) % 3) == 2) && !ga;
                    end
                    check("capture21", sel_in(c, pin_set[2], pin_set[3], sync_set[1], sync_set[3]), cap21);
                    check("capture20", sel_in(c, pin_set[0], pin_set[1], sync_set[0], sync_set[2]), cap20);
                    check("freerun", sel_in({1'b0, f}, pin_set[4], pin_set[5], 1'b0, 1'b0), frun);
                    check("trip input", sel_in({1'b0, f}, pin_set[6], pin_set[7], 1'b0, 1'b0), trip);
                    check("gpio handover", ga, gpio);
                    check("pin0 enable", e0, p0_oe);
                    check("pin1 enable", e1, p1_oe);
                    check("pin0 data", e0 & wave_set, p0_out);
                    check("pin1 data", e1 & wave_set, p1_out);
                end
            end
        end
    endtask : run_routes

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        dstby_rst_n = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = '0;
        wdata = '0;
        pin_set = '0;
        sync_set = '0;
        wave_set = '0;
        flag_set = 1'b0;
        mismatches = 0;
        tests_run = 0;
        cycles = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        reg_read(`TU2_PFS_OFFSET, got);
        check("reset word", `TU2_PFS_RESET, got);
        check("reset pin0 enable", 6'h00, p0_oe);
        reg_write(8'h04, 32'h0000_0155);
        reg_read(`TU2_PFS_OFFSET, got);
        check("unmapped write", `TU2_PFS_RESET, got);
        reg_read(8'h04, got);
        check("unmapped read", 32'h0000_0000, got);
        run_routes();
        @(posedge clk);
        dstby_rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        dstby_rst_n <= 1'b1;
        @(negedge clk);
        check("standby capture21", 32'h0000_0000, cap21);
        reg_read(`TU2_PFS_OFFSET, got);
        check("after standby reset", word, got);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        reg_read(`TU2_PFS_OFFSET, got);
        check("after full reset", `TU2_PFS_RESET, got);
        stop_test();
    end
endmodule : tu2_pin_func_sel_test
`default_nettype wire
